// ==== hdl/bsp_pkg.sv ====
package bsp_pkg;

   // operating mode strap codes on the three select pins
   localparam logic [2:0] MODE_SINGLE_CHIP = 3'h3;
   localparam logic [2:0] MODE_EXT_BUS8 = 3'h1;

   // bit positions on port 5
   localparam int P5_BUS_CLK = 0;
   localparam int P5_READY = 1;
   localparam int P5_HOLD_GRANT = 2;
   localparam int P5_HOLD_REQ = 3;
   localparam int P5_UPPER_WR = 4;
   localparam int P5_LOWER_WR = 5;
   localparam int P5_READ_STB = 6;
   localparam int P5_RAM_WR_BLOCK = 7;

   // bit positions on port 7 and port 8
   localparam int P7_SER1_CLK = 0;
   localparam int P7_SER1_RX = 1;
   localparam int P7_SER1_TX = 2;
   localparam int P7_SER0_CLK = 3;
   localparam int P7_SER0_RX = 4;
   localparam int P7_SER0_TX = 5;
   localparam int P8_TRIG = 2;

   // values after reset and while a function is idle
   localparam logic [7:0] PORT_RST = 8'h00;
   localparam logic READY_IDLE = 1'h1;
   localparam logic RX_IDLE = 1'h1;
   localparam logic CTS_IDLE = 1'h0;

   // one port: data latch and direction (1 = output)
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
   } bsp_port_s;

   typedef struct packed {
      logic ext_bus;
      logic bus16;
   } bsp_mode_s;

   // per-function enables from the peripheral control registers
   typedef struct packed {
      logic clk_out_en;
      logic ready_en;
      logic hold_en;
      logic upper_wr_en;
      logic lower_wr_en;
      logic s0_clk_out_en;
      logic s0_ext_clk;
      logic s0_tx_en;
      logic s0_rx_en;
      logic s0_cts_en;
      logic s1_clk_out_en;
      logic s1_ext_clk;
      logic s1_tx_en;
      logic s1_rx_en;
      logic [3:0] irq_en;
      logic trig_en;
   } bsp_func_en_s;

   // outgoing peripheral signals that may own a pin
   typedef struct packed {
      logic bus_clk;
      logic hold_grant;
      logic upper_wr;
      logic lower_wr;
      logic read_stb;
      logic s0_clk;
      logic s0_tx;
      logic s1_clk;
      logic s1_tx;
   } bsp_per_out_s;

   // incoming pin functions handed to the peripherals
   typedef struct packed {
      logic ready;
      logic hold_req;
      logic ram_wr_block;
      logic s0_cts;
      logic s0_rx;
      logic s0_ext_clk;
      logic s1_rx;
      logic s1_ext_clk;
      logic [3:0] irq;
      logic trig;
   } bsp_per_in_s;

   function automatic bsp_mode_s bsp_decode_mode(input logic [2:0] sel);
      bsp_mode_s m;
      m.ext_bus = (sel != MODE_SINGLE_CHIP);
      m.bus16 = (sel != MODE_SINGLE_CHIP) && (sel != MODE_EXT_BUS8);
      return m;
   endfunction

endpackage

// ==== hdl/bsp_sync.sv ====
`timescale 1ns/10ps
module bsp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

// ==== hdl/bsp_pin_mux.sv ====
`timescale 1ns/10ps
//Contract
// R1: bus clock on port5_bit0 in external mode; code drives it only when clk_out_en is also set
// R2: ready from port5_bit1 only when enabled
// R3: hold grant on port5_bit2 when hold enabled
// R4: hold request sampled from port5_bit3
// R5: upper write strobe only in 16-bit mode
// R6: lower write strobe when enabled, external mode
// R7: read strobe on port5_bit6 in external mode
// R8: port5_bit7 port bit, watched as write block
// R9: port6 open-drain port or analog input
// R10: serial1 clock out or external clock in
// R11: serial1 transmit data when enabled
// R12: serial0 clock out or external clock in
// R13: serial0 transmit data when enabled
// R14: receive data read, pins stay port bits
// R15: port5_bit4 serves as serial0 clear-to-send
// R16: four external interrupts sampled when enabled
// R17: converter trigger taken from port8_bit2
// R18: board ties mode select pins high/low
// R19: enabled function owns the output driver
module bsp_pin_mux (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // mode select straps
   input wire logic OPMODE_SELECT_A_I,
   input wire logic OPMODE_SELECT_B_I,
   input wire logic OPMODE_SELECT_C_I,
   // port latches and function enables
   input wire bsp_pkg::bsp_port_s PORT5_CTL_I,
   input wire bsp_pkg::bsp_port_s PORT6_CTL_I,
   input wire bsp_pkg::bsp_port_s PORT7_CTL_I,
   input wire bsp_pkg::bsp_port_s PORT8_CTL_I,
   input wire logic [7:0] ANALOG_EN_I,
   input wire bsp_pkg::bsp_func_en_s FUNC_EN_I,
   // peripheral side
   input wire bsp_pkg::bsp_per_out_s PER_OUT_I,
   output bsp_pkg::bsp_per_in_s PER_IN_O,
   output logic [7:0] ANALOG_SEL_O,
   output logic EXT_BUS_MODE_O,
   output logic BUS16_MODE_O,
   // port read-back
   output logic [7:0] PORT5_IN_O,
   output logic [7:0] PORT6_IN_O,
   output logic [5:0] PORT7_IN_O,
   output logic [2:0] PORT8_IN_O,
   // pins
   input wire logic [7:0] PORT5_I,
   output logic [7:0] PORT5_O,
   output logic [7:0] PORT5_OE_O,
   input wire logic [7:0] PORT6_I,
   output logic [7:0] PORT6_O,
   output logic [7:0] PORT6_OE_O,
   input wire logic [5:0] PORT7_I,
   output logic [5:0] PORT7_O,
   output logic [5:0] PORT7_OE_O,
   input wire logic [2:0] PORT8_I,
   output logic [2:0] PORT8_O,
   output logic [2:0] PORT8_OE_O
);
   // {oe, o}: a function wins, an input-only function floats, else the port latch
   function automatic logic [1:0] pin_drive(input logic sel, input logic fval, input logic in_only,
                                            input logic dir, input logic data);
      logic [1:0] r;
      r = {dir, data};
      if (sel) begin
         r = {1'h1, fval};
      end else if (in_only) begin
         r = 2'h0;
      end
      return r;
   endfunction

   logic [27:0] pin_raw;
   logic [27:0] pin_s;
   logic [7:0] p5_s;
   logic [7:0] p6_s;
   logic [5:0] p7_s;
   logic [2:0] p8_s;
   logic [2:0] mode_s;
   bsp_pkg::bsp_mode_s mode_q;
   bsp_pkg::bsp_mode_s mode_d;
   bsp_pkg::bsp_func_en_s en;
   bsp_pkg::bsp_per_out_s po;
   bsp_pkg::bsp_per_in_s per_in_d;

   // pins arrive from outside the clock domain
   assign pin_raw = {OPMODE_SELECT_C_I, OPMODE_SELECT_B_I, OPMODE_SELECT_A_I,
                     PORT8_I, PORT7_I, PORT6_I, PORT5_I};

   bsp_sync #(.W(28)) u_sync (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .d_i(pin_raw),
      .q_o(pin_s)
   );

   assign p5_s = pin_s[7:0];
   assign p6_s = pin_s[15:8];
   assign p7_s = pin_s[21:16];
   assign p8_s = pin_s[24:22];
   assign mode_s = pin_s[27:25];
   assign en = FUNC_EN_I;
   assign po = PER_OUT_I;

   // R18 straps are static, so following them after release is safe
   assign mode_d = bsp_pkg::bsp_decode_mode(mode_s);

   // ---------------- port 5 ----------------
   logic [7:0] p5_sel;
   logic [7:0] p5_val;
   logic [7:0] p5_in_only;
   logic [7:0] p5_o_d;
   logic [7:0] p5_oe_d;
   logic ready_act;
   logic hold_act;

   assign ready_act = mode_q.ext_bus && en.ready_en;
   assign hold_act = mode_q.ext_bus && en.hold_en;

   // R1 bus clock select
   assign p5_sel[bsp_pkg::P5_BUS_CLK] = mode_q.ext_bus && en.clk_out_en;
   assign p5_val[bsp_pkg::P5_BUS_CLK] = po.bus_clk;
   // R2 ready pin becomes input
   assign p5_sel[bsp_pkg::P5_READY] = 1'h0;
   assign p5_val[bsp_pkg::P5_READY] = 1'h0;
   // R3 hold grant select
   assign p5_sel[bsp_pkg::P5_HOLD_GRANT] = hold_act;
   assign p5_val[bsp_pkg::P5_HOLD_GRANT] = po.hold_grant;
   // R4 hold request pin input
   assign p5_sel[bsp_pkg::P5_HOLD_REQ] = 1'h0;
   assign p5_val[bsp_pkg::P5_HOLD_REQ] = 1'h0;
   // R5 upper strobe needs 16-bit bus
   assign p5_sel[bsp_pkg::P5_UPPER_WR] = mode_q.ext_bus && mode_q.bus16 && en.upper_wr_en;
   assign p5_val[bsp_pkg::P5_UPPER_WR] = po.upper_wr;
   // R6 lower strobe select
   assign p5_sel[bsp_pkg::P5_LOWER_WR] = mode_q.ext_bus && en.lower_wr_en;
   assign p5_val[bsp_pkg::P5_LOWER_WR] = po.lower_wr;
   // R7 read strobe in any external mode
   assign p5_sel[bsp_pkg::P5_READ_STB] = mode_q.ext_bus;
   assign p5_val[bsp_pkg::P5_READ_STB] = po.read_stb;
   // R8 write-block pin never loses its port
   assign p5_sel[bsp_pkg::P5_RAM_WR_BLOCK] = 1'h0;
   assign p5_val[bsp_pkg::P5_RAM_WR_BLOCK] = 1'h0;

   // dedicated inputs float the driver; shared inputs leave it to software
   assign p5_in_only = {4'h0, hold_act, 1'h0, ready_act, 1'h0};

   // ---------------- port 7 ----------------
   logic [5:0] p7_sel;
   logic [5:0] p7_val;
   logic [5:0] p7_o_d;
   logic [5:0] p7_oe_d;

   // R10 serial1 clock out
   assign p7_sel[bsp_pkg::P7_SER1_CLK] = en.s1_clk_out_en;
   assign p7_val[bsp_pkg::P7_SER1_CLK] = po.s1_clk;
   // R14 receive pins keep the port
   assign p7_sel[bsp_pkg::P7_SER1_RX] = 1'h0;
   assign p7_val[bsp_pkg::P7_SER1_RX] = 1'h0;
   // R11 serial1 transmit
   assign p7_sel[bsp_pkg::P7_SER1_TX] = en.s1_tx_en;
   assign p7_val[bsp_pkg::P7_SER1_TX] = po.s1_tx;
   // R12 serial0 clock out
   assign p7_sel[bsp_pkg::P7_SER0_CLK] = en.s0_clk_out_en;
   assign p7_val[bsp_pkg::P7_SER0_CLK] = po.s0_clk;
   assign p7_sel[bsp_pkg::P7_SER0_RX] = 1'h0;
   assign p7_val[bsp_pkg::P7_SER0_RX] = 1'h0;
   // R13 serial0 transmit
   assign p7_sel[bsp_pkg::P7_SER0_TX] = en.s0_tx_en;
   assign p7_val[bsp_pkg::P7_SER0_TX] = po.s0_tx;

   // R19 enabled function takes the driver
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p5
         assign {p5_oe_d[gi], p5_o_d[gi]} = pin_drive(p5_sel[gi], p5_val[gi], p5_in_only[gi],
                                                      PORT5_CTL_I.dir[gi], PORT5_CTL_I.data[gi]);
      end
      for (gi = 0; gi < 6; gi++) begin : g_p7
         assign {p7_oe_d[gi], p7_o_d[gi]} = pin_drive(p7_sel[gi], p7_val[gi], 1'h0,
                                                      PORT7_CTL_I.dir[gi], PORT7_CTL_I.data[gi]);
      end
   endgenerate

   // ---------------- port 6 ----------------
   logic [7:0] p6_oe_d;
   logic [7:0] p6_in_d;
   // R9 open drain pulls low only; analog select floats the pin
   assign p6_oe_d = ~ANALOG_EN_I & PORT6_CTL_I.dir[7:0] & ~PORT6_CTL_I.data[7:0];
   // analog bits read as zero so the digital reader sees no half-level noise
   assign p6_in_d = p6_s & ~ANALOG_EN_I;

   // ---------------- inputs to peripherals ----------------
   // R2 ready held active when the function is unused
   assign per_in_d.ready = ready_act ? p5_s[bsp_pkg::P5_READY] : bsp_pkg::READY_IDLE;
   // R4 hold request sampled only while hold is active, else held low
   assign per_in_d.hold_req = hold_act && p5_s[bsp_pkg::P5_HOLD_REQ];
   // R8 write block watched always
   assign per_in_d.ram_wr_block = p5_s[bsp_pkg::P5_RAM_WR_BLOCK];
   // R15 clear-to-send from the shared strobe pin
   assign per_in_d.s0_cts = en.s0_cts_en ? p5_s[bsp_pkg::P5_UPPER_WR] : bsp_pkg::CTS_IDLE;
   // R14 receive data taken during reception
   assign per_in_d.s0_rx = en.s0_rx_en ? p7_s[bsp_pkg::P7_SER0_RX] : bsp_pkg::RX_IDLE;
   assign per_in_d.s1_rx = en.s1_rx_en ? p7_s[bsp_pkg::P7_SER1_RX] : bsp_pkg::RX_IDLE;
   // R12 external clock needs an input pin
   assign per_in_d.s0_ext_clk = en.s0_ext_clk && !en.s0_clk_out_en && !PORT7_CTL_I.dir[bsp_pkg::P7_SER0_CLK]
                                && p7_s[bsp_pkg::P7_SER0_CLK];
   // R10 external clock needs an input pin
   assign per_in_d.s1_ext_clk = en.s1_ext_clk && !en.s1_clk_out_en && !PORT7_CTL_I.dir[bsp_pkg::P7_SER1_CLK]
                                && p7_s[bsp_pkg::P7_SER1_CLK];
   // R16 interrupt sources gated by their enables
   assign per_in_d.irq = en.irq_en & {p5_s[bsp_pkg::P5_UPPER_WR], p8_s};
   // R17 converter trigger
   assign per_in_d.trig = en.trig_en && p8_s[bsp_pkg::P8_TRIG];

   // registered pin drive costs one cycle but keeps pads glitch free
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         mode_q <= '0;
         PORT5_O <= bsp_pkg::PORT_RST;
         PORT5_OE_O <= bsp_pkg::PORT_RST;
         PORT6_OE_O <= bsp_pkg::PORT_RST;
         PORT7_O <= bsp_pkg::PORT_RST[5:0];
         PORT7_OE_O <= bsp_pkg::PORT_RST[5:0];
         PORT8_O <= bsp_pkg::PORT_RST[2:0];
         PORT8_OE_O <= bsp_pkg::PORT_RST[2:0];
      end else begin
         mode_q <= mode_d;
         PORT5_O <= p5_o_d;
         PORT5_OE_O <= p5_oe_d;
         PORT6_OE_O <= p6_oe_d;
         PORT7_O <= p7_o_d;
         PORT7_OE_O <= p7_oe_d;
         PORT8_O <= PORT8_CTL_I.data[2:0];
         PORT8_OE_O <= PORT8_CTL_I.dir[2:0];
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         PER_IN_O <= '0;
         ANALOG_SEL_O <= 8'h00;
         PORT5_IN_O <= 8'h00;
         PORT6_IN_O <= 8'h00;
         PORT7_IN_O <= 6'h00;
         PORT8_IN_O <= 3'h0;
      end else begin
         PER_IN_O <= per_in_d;
         ANALOG_SEL_O <= ANALOG_EN_I;
         PORT5_IN_O <= p5_s;
         PORT6_IN_O <= p6_in_d;
         PORT7_IN_O <= p7_s;
         PORT8_IN_O <= p8_s;
      end
   end

   // open-drain data is always low
   assign PORT6_O = 8'h00;
   assign EXT_BUS_MODE_O = mode_q.ext_bus;
   assign BUS16_MODE_O = mode_q.bus16;

   // ---------------- checks ----------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   AST_BUS_CLK: assert property ( // R1
      (mode_q.ext_bus && en.clk_out_en) |=> (PORT5_OE_O[0] && PORT5_O[0] == $past(po.bus_clk)))
      else $error("bus clock not driven on port5 bit0");

   AST_BUS_CLK_PORT: assert property ( // R1
      (RST_N_I && !mode_q.ext_bus) |=> (PORT5_OE_O[0] == $past(PORT5_CTL_I.dir[0])))
      else $error("port5 bit0 not a port in single-chip mode");

   AST_READY_IDLE: assert property ( // R2
      (RST_N_I && !ready_act) |=> PER_IN_O.ready)
      else $error("ready not idle while function unused");

   AST_READY_IN: assert property ( // R2
      ready_act |=> (!PORT5_OE_O[1] && PER_IN_O.ready == $past(p5_s[1])))
      else $error("ready pin not taken as input");

   AST_HOLD_GRANT: assert property ( // R3
      hold_act |=> (PORT5_OE_O[2] && PORT5_O[2] == $past(po.hold_grant)))
      else $error("hold grant not driven");

   AST_HOLD_REQ: assert property ( // R4
      hold_act ##1 hold_act |=> (PER_IN_O.hold_req == $past(p5_s[3]) && !PORT5_OE_O[3]))
      else $error("hold request not sampled");

   AST_UPPER_WR: assert property ( // R5
      (RST_N_I && !mode_q.bus16) |=>
      (PORT5_OE_O[4] == $past(PORT5_CTL_I.dir[4]) && PORT5_O[4] == $past(PORT5_CTL_I.data[4])))
      else $error("upper strobe driven outside 16-bit mode");

   AST_LOWER_WR: assert property ( // R6
      (mode_q.ext_bus && en.lower_wr_en) |=> (PORT5_OE_O[5] && PORT5_O[5] == $past(po.lower_wr)))
      else $error("lower strobe not driven");

   AST_READ_STB: assert property ( // R7
      mode_q.ext_bus |=> (PORT5_OE_O[6] && PORT5_O[6] == $past(po.read_stb)))
      else $error("read strobe not driven in external mode");

   AST_WR_BLOCK: assert property ( // R8
      RST_N_I |=> (PER_IN_O.ram_wr_block == $past(p5_s[7]) && PORT5_OE_O[7] == $past(PORT5_CTL_I.dir[7])))
      else $error("write block pin not watched or port lost");

   AST_ANALOG: assert property ( // R9
      RST_N_I |=> ((PORT6_OE_O & $past(ANALOG_EN_I)) == 8'h00 && ANALOG_SEL_O == $past(ANALOG_EN_I)))
      else $error("analog pin driven");

   AST_SER0_TX: assert property ( // R13
      (RST_N_I && en.s0_tx_en) |=> (PORT7_OE_O[5] && PORT7_O[5] == $past(po.s0_tx)))
      else $error("serial0 transmit not driven");

   AST_SER1_TX: assert property ( // R11
      (RST_N_I && en.s1_tx_en) |=> (PORT7_OE_O[2] && PORT7_O[2] == $past(po.s1_tx)))
      else $error("serial1 transmit not driven");

   AST_SER0_CLK: assert property ( // R12
      (RST_N_I && en.s0_clk_out_en) |=> (PORT7_OE_O[3] && PORT7_O[3] == $past(po.s0_clk)))
      else $error("serial0 clock not driven");

   AST_SER1_CLK: assert property ( // R10
      (RST_N_I && en.s1_clk_out_en) |=> (PORT7_OE_O[0] && PORT7_O[0] == $past(po.s1_clk)))
      else $error("serial1 clock not driven");

   AST_EXT_CLK_OFF: assert property ( // R10
      (en.s1_clk_out_en || PORT7_CTL_I.dir[0] || !en.s1_ext_clk) |=> !PER_IN_O.s1_ext_clk)
      else $error("serial1 external clock taken while refused");

   AST_RX_IDLE: assert property ( // R14
      (RST_N_I && !en.s0_rx_en && !en.s1_rx_en) |=> (PER_IN_O.s0_rx && PER_IN_O.s1_rx))
      else $error("receive data not idle while disabled");

   AST_CTS_IDLE: assert property ( // R15
      !en.s0_cts_en |=> !PER_IN_O.s0_cts)
      else $error("clear-to-send passed while disabled");

   AST_TRIG: assert property ( // R17
      RST_N_I |=> (PER_IN_O.trig == ($past(en.trig_en) && $past(p8_s[bsp_pkg::P8_TRIG]))))
      else $error("converter trigger not taken");

   AST_IRQ: assert property ( // R16
      (en.irq_en == 4'h0) |=> (PER_IN_O.irq == 4'h0))
      else $error("interrupt passed while disabled");

endmodule

// ==== tb/bsp_pin_partner.sv ====
`timescale 1ns/10ps
module bsp_pin_partner (
   // strap code and far-side drive
   input wire logic [2:0] mode_i,
   input wire logic [7:0] drv5_i,
   input wire logic [7:0] drv6_i,
   input wire logic [5:0] drv7_i,
   input wire logic [2:0] drv8_i,
   // device pin drivers
   input wire logic [7:0] o5_i,
   input wire logic [7:0] oe5_i,
   input wire logic [7:0] oe6_i,
   input wire logic [5:0] o7_i,
   input wire logic [5:0] oe7_i,
   input wire logic [2:0] o8_i,
   input wire logic [2:0] oe8_i,
   // resolved pin levels
   output logic [7:0] pin5_o,
   output logic [7:0] pin6_o,
   output logic [5:0] pin7_o,
   output logic [2:0] pin8_o,
   output logic [2:0] straps_o
);
   assign straps_o = mode_i;
   assign pin5_o = (oe5_i & o5_i) | (~oe5_i & drv5_i);
   assign pin6_o = ~oe6_i & drv6_i;
   assign pin7_o = (oe7_i & o7_i) | (~oe7_i & drv7_i);
   assign pin8_o = (oe8_i & o8_i) | (~oe8_i & drv8_i);
endmodule

// ==== tb/bsp_pin_mux_tb.sv ====
`timescale 1ns/10ps
module bsp_pin_mux_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] mode = 3'h3;
   logic [2:0] strap;
   bsp_pkg::bsp_port_s c5, c6, c7, c8;
   bsp_pkg::bsp_func_en_s fe;
   bsp_pkg::bsp_per_out_s po;
   bsp_pkg::bsp_per_in_s per_in, ei;
   logic [7:0] an, an_sel, drv5, drv6, in5, in6, pin5, pin6, o5, oe5, o6, oe6, p5, p6;
   logic [5:0] drv7, in7, pin7, o7, oe7, p7;
   logic [2:0] drv8, in8, pin8, o8, oe8, p8;
   logic [15:0] e5, e6, e7, e8;
   logic ext_o, b16_o, ext, b16;
   logic [31:0] seed = 32'h97876e93;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;

   always #5 mclk = ~mclk;

   bsp_pin_mux bsp_pin_mux_inst (
      .MCLK_I(mclk), .RST_N_I(rst_n),
      .OPMODE_SELECT_A_I(strap[0]), .OPMODE_SELECT_B_I(strap[1]), .OPMODE_SELECT_C_I(strap[2]),
      .PORT5_CTL_I(c5), .PORT6_CTL_I(c6), .PORT7_CTL_I(c7), .PORT8_CTL_I(c8),
      .ANALOG_EN_I(an), .FUNC_EN_I(fe), .PER_OUT_I(po), .PER_IN_O(per_in),
      .ANALOG_SEL_O(an_sel), .EXT_BUS_MODE_O(ext_o), .BUS16_MODE_O(b16_o),
      .PORT5_IN_O(in5), .PORT6_IN_O(in6), .PORT7_IN_O(in7), .PORT8_IN_O(in8),
      .PORT5_I(pin5), .PORT5_O(o5), .PORT5_OE_O(oe5), .PORT6_I(pin6), .PORT6_O(o6), .PORT6_OE_O(oe6),
      .PORT7_I(pin7), .PORT7_O(o7), .PORT7_OE_O(oe7), .PORT8_I(pin8), .PORT8_O(o8), .PORT8_OE_O(oe8)
   );

   bsp_pin_partner bsp_pin_partner_inst (
      .mode_i(mode), .drv5_i(drv5), .drv6_i(drv6), .drv7_i(drv7), .drv8_i(drv8),
      .o5_i(o5), .oe5_i(oe5), .oe6_i(oe6), .o7_i(o7), .oe7_i(oe7), .o8_i(o8), .oe8_i(oe8),
      .pin5_o(pin5), .pin6_o(pin6), .pin7_o(pin7), .pin8_o(pin8), .straps_o(strap)
   );

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // first two passes are the all-on and all-off corners
   function automatic logic [31:0] pick(input int i);
      return (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : rnd();
   endfunction

   // owning function takes the driver; forced-off bits float
   function automatic logic [15:0] drive(input logic [7:0] dir, input logic [7:0] dat,
      input logic [7:0] own, input logic [7:0] fv, input logic [7:0] off);
      return {(dir | own) & ~off, (dat & ~own) | (fv & own)};
   endfunction

   task automatic summarize();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cmp_out(input logic [7:0] goe, input logic [7:0] go, input logic [15:0] e);
      n_tests++;
      if (goe !== e[15:8] || (go & e[15:8]) !== (e[7:0] & e[15:8])) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, {goe, go & e[15:8]}, {e[15:8], e[7:0] & e[15:8]});
      end
   endtask

   task automatic cmp_in(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic calc();
      ext = (mode != bsp_pkg::MODE_SINGLE_CHIP);
      b16 = ext && (mode != bsp_pkg::MODE_EXT_BUS8);
      e5 = drive(c5.dir, c5.data,
         {1'b0, ext, ext & fe.lower_wr_en, b16 & fe.upper_wr_en, 1'b0, ext & fe.hold_en, 1'b0, ext & fe.clk_out_en},
         {1'b0, po.read_stb, po.lower_wr, po.upper_wr, 1'b0, po.hold_grant, 1'b0, po.bus_clk},
         {4'h0, ext & fe.hold_en, 1'b0, ext & fe.ready_en, 1'b0});
      e6 = {~an & c6.dir & ~c6.data, 8'h00};
      e7 = drive({2'h0, c7.dir[5:0]}, {2'h0, c7.data[5:0]},
         {2'h0, fe.s0_tx_en, 1'b0, fe.s0_clk_out_en, fe.s1_tx_en, 1'b0, fe.s1_clk_out_en},
         {2'h0, po.s0_tx, 1'b0, po.s0_clk, po.s1_tx, 1'b0, po.s1_clk}, 8'h00);
      e8 = drive({5'h0, c8.dir[2:0]}, {5'h0, c8.data[2:0]}, 8'h00, 8'h00, 8'h00);
      p5 = (e5[15:8] & e5[7:0]) | (~e5[15:8] & drv5);
      p6 = ~e6[15:8] & drv6;
      p7 = (e7[13:8] & e7[5:0]) | (~e7[13:8] & drv7);
      p8 = (e8[10:8] & e8[2:0]) | (~e8[10:8] & drv8);
   endtask

   task automatic stim(input int i);
      logic [31:0] r;
      r = pick(i);
      fe <= r[18:0];
      c5 <= r[31:16];
      r = pick(i);
      po <= r[8:0];
      c6 <= r[31:16];
      r = pick(i);
      c7 <= r[15:0];
      c8 <= r[31:16];
      r = pick(i);
      an <= r[7:0];
      drv5 <= r[15:8];
      drv6 <= r[23:16];
      drv7 <= r[29:24];
      r = pick(i);
      drv8 <= r[2:0];
   endtask

   task automatic check_out();
      calc();
      cmp_out(oe5, o5, e5);
      cmp_out(oe6, o6, e6);
      cmp_out({2'h0, oe7}, {2'h0, o7}, e7);
      cmp_out({5'h0, oe8}, {5'h0, o8}, e8);
      cmp_in({56'h0, an_sel}, {56'h0, an});
   endtask

   task automatic check_in();
      calc();
      ei.ready = (ext && fe.ready_en) ? p5[1] : bsp_pkg::READY_IDLE;
      ei.hold_req = (ext && fe.hold_en) & p5[3];
      ei.ram_wr_block = p5[7];
      ei.s0_cts = fe.s0_cts_en ? p5[4] : bsp_pkg::CTS_IDLE;
      ei.s0_rx = fe.s0_rx_en ? p7[4] : bsp_pkg::RX_IDLE;
      ei.s0_ext_clk = ~fe.s0_clk_out_en & ~c7.dir[3] & fe.s0_ext_clk & p7[3];
      ei.s1_rx = fe.s1_rx_en ? p7[1] : bsp_pkg::RX_IDLE;
      ei.s1_ext_clk = ~fe.s1_clk_out_en & ~c7.dir[0] & fe.s1_ext_clk & p7[0];
      ei.irq = {p5[4], p8} & fe.irq_en;
      ei.trig = fe.trig_en & p8[2];
      cmp_in({51'h0, per_in}, {51'h0, ei});
      cmp_in({37'h0, in5, in6, in7, in8, ext_o, b16_o}, {37'h0, p5, p6 & ~an, p7, p8, ext, b16});
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end

   initial begin
      {c5, c6, c7, c8, an, fe, po} = '0;
      {drv5, drv6, drv7, drv8} = '0;
      repeat (12) @(posedge mclk);
      #1;
      cmp_in({25'h0, oe5, oe6, oe7, oe8, per_in, ext_o}, 64'h0);
      @(posedge mclk);
      rst_n <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         mode <= m[2:0];
         repeat (6) @(posedge mclk);
         for (int i = 0; i < 12; i++) begin
            stim(i);
            @(posedge mclk);
            #1;
            check_out();
            repeat (3) @(posedge mclk);
            #1;
            check_in();
            @(posedge mclk);
         end
         $display("test mode %h done", m[2:0]);
      end
      summarize();
   end
endmodule
